/* File: hdl/regulator_ctrl_pkg.sv */
package regulator_ctrl_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] REG_ONE_CONTROL_ADDR  = 8'h3c;
    localparam logic [7:0] REG_TWO_VOLTAGE_ADDR  = 8'h3d;
    localparam logic [7:0] REG_ONE_VOLTAGE_ADDR  = 8'h3b;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int POLICY_MSB       = 7;
    localparam int POLICY_LSB       = 5;
    localparam int PG_ENABLE_BIT    = 3;
    localparam int PG_STATUS_BIT    = 1;
    localparam int SHIP_KEEP_BIT    = 0;
    localparam int BYPASS_BIT       = 6;
    localparam int VCODE_MSB        = 5;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [2:0] POLICY_RESET     = 3'h1;
    localparam logic       PG_ENABLE_RESET  = 1'h1;
    localparam logic       SHIP_KEEP_RESET  = 1'h0;
    localparam logic       BYPASS_RESET     = 1'h0;
    localparam logic [5:0] VCODE_TWO_RESET  = 6'h32;
    localparam logic [5:0] VCODE_ONE_RESET  = 6'h14;

    ////////////////////////////////////////////////////////////////////////////////
    // Voltage encoding
    localparam logic [5:0] VCODE_MAX        = 6'h38;
    localparam int         VOUT_OFFSET_MV   = 800;
    localparam int         VOUT_STEP_MV     = 50;

    ////////////////////////////////////////////////////////////////////////////////
    // Enable policy codes
    typedef enum logic [2:0] {
        POLICY_SLOT_A   = 3'b000,
        POLICY_SLOT_B   = 3'b001,
        POLICY_SLOT_C   = 3'b010,
        POLICY_SLOT_D   = 3'b011,
        POLICY_OFF      = 3'b100,
        POLICY_ON       = 3'b101,
        POLICY_PIN      = 3'b110,
        POLICY_ALWAYS   = 3'b111
    } enable_policy_t;

endpackage : regulator_ctrl_pkg

/* File: hdl/linear_regulator_control_regs.sv */
// Operation
// - Codes 0-3: sequenced at slot a-d
// - Code 4 off, code 5 on, unsequenced
// - Code 6 follows general-purpose pin four
// - Code 7 keeps regulator one always on
// - Bit 3 enables power-good monitoring, reset on
// - Bit 1 reads power-good status
// - Ship bit 0: power down entering ship, except under code 7
// - Ship bit 1: stay on in ship mode, except under code 4
// - Regulator two bit 6 selects bypass
// - Regulator two code clamps above 38h
// - Regulator one code uses same clamping
`timescale 1ns/1ps
module linear_regulator_control_regs
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       registerReset,
    // Register port
    input  wire logic       regWrite,
    input  wire logic       regRead,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWriteData,
    output logic      [7:0] regReadData,
    output logic            regReadValid,
    // Power sequencer
    input  wire logic [3:0] sequenceSlotActive,
    input  wire logic       shipPowerDown,
    input  wire logic       regulatorOnePowerGoodRaw,
    input  wire logic       generalPurposePinFour,
    input  wire logic [5:0] regulatorOneVoltageCode,
    // Regulator controls
    output logic            regulatorOneEnable,
    output logic            regulatorOnePowerGoodEnable,
    output logic            regulatorOneSkipShipDown,
    output logic      [5:0] regulatorOneVoltageApplied,
    output logic            regulatorTwoBypass,
    output logic      [5:0] regulatorTwoVoltageApplied
);
    import regulator_ctrl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Clamp of a voltage code
    function automatic logic [5:0] clampCode(input logic [5:0] code);
        clampCode = (code > VCODE_MAX) ? VCODE_MAX : code;
    endfunction : clampCode

    // Address decode, shared by the write and read paths
    function automatic logic hitsControlOne(input logic [7:0] addr);
        hitsControlOne = (addr == REG_ONE_CONTROL_ADDR);
    endfunction : hitsControlOne

    function automatic logic hitsVoltageTwo(input logic [7:0] addr);
        hitsVoltageTwo = (addr == REG_TWO_VOLTAGE_ADDR);
    endfunction : hitsVoltageTwo

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic      [1:0] syncIn;
    wire logic [1:0] syncLevel;
    logic            pinLevel;
    logic            pgLevel;

    assign syncIn = {regulatorOnePowerGoodRaw, generalPurposePinFour};

    for (genvar g = 0; g < 2; g++) begin : gen_sync
        logic first;
        logic next_first;
        logic second;
        logic next_second;

        always_comb begin
            next_first  = syncIn[g];
            next_second = first;
        end

        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                first  <= 1'b0;
                second <= 1'b0;
            end else begin
                first  <= next_first;
                second <= next_second;
            end
        end

        assign syncLevel[g] = second;
    end : gen_sync

    assign pinLevel = syncLevel[0];
    assign pgLevel  = syncLevel[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Regulator one control register
    enable_policy_t policy;
    enable_policy_t next_policy;
    logic           pgEnable;
    logic           next_pgEnable;
    logic           shipKeep;
    logic           next_shipKeep;
    logic           writeOne;
    logic           writeTwo;

    assign writeOne = regWrite && hitsControlOne(regAddr);
    assign writeTwo = regWrite && hitsVoltageTwo(regAddr);

    always_comb begin
        next_policy   = policy;
        next_pgEnable = pgEnable;
        next_shipKeep = shipKeep;
        if (registerReset) begin
            next_policy   = enable_policy_t'(POLICY_RESET);
            next_pgEnable = PG_ENABLE_RESET;
            next_shipKeep = SHIP_KEEP_RESET;
        end else if (writeOne) begin
            next_policy   = enable_policy_t'(regWriteData[POLICY_MSB:POLICY_LSB]);
            next_pgEnable = regWriteData[PG_ENABLE_BIT];
            next_shipKeep = regWriteData[SHIP_KEEP_BIT];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            policy   <= enable_policy_t'(POLICY_RESET);
            pgEnable <= PG_ENABLE_RESET;
            shipKeep <= SHIP_KEEP_RESET;
        end else begin
            policy   <= next_policy;
            pgEnable <= next_pgEnable;
            shipKeep <= next_shipKeep;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Regulator two voltage and mode register
    logic       bypass;
    logic       next_bypass;
    logic [5:0] vcodeTwo;
    logic [5:0] next_vcodeTwo;

    always_comb begin
        next_bypass   = bypass;
        next_vcodeTwo = vcodeTwo;
        if (registerReset) begin
            next_vcodeTwo = VCODE_TWO_RESET;
        end else if (writeTwo) begin
            next_bypass   = regWriteData[BYPASS_BIT];
            next_vcodeTwo = regWriteData[VCODE_MSB:0];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bypass   <= BYPASS_RESET;
            vcodeTwo <= VCODE_TWO_RESET;
        end else begin
            bypass   <= next_bypass;
            vcodeTwo <= next_vcodeTwo;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Enable decode
    logic next_regulatorOneEnable;

    always_comb begin
        unique case (policy)
            POLICY_SLOT_A: next_regulatorOneEnable = sequenceSlotActive[0];
            POLICY_SLOT_B: next_regulatorOneEnable = sequenceSlotActive[1];
            POLICY_SLOT_C: next_regulatorOneEnable = sequenceSlotActive[2];
            POLICY_SLOT_D: next_regulatorOneEnable = sequenceSlotActive[3];
            POLICY_OFF:    next_regulatorOneEnable = 1'b0;
            POLICY_ON:     next_regulatorOneEnable = 1'b1;
            POLICY_PIN:    next_regulatorOneEnable = pinLevel;
            POLICY_ALWAYS: next_regulatorOneEnable = 1'b1;
        endcase
        // Ship power-down drops the rail unless keep-on is set or the policy is POLICY_ALWAYS
        if (shipPowerDown && !shipKeep && policy != POLICY_ALWAYS) begin
            next_regulatorOneEnable = 1'b0;
        end else if (shipPowerDown && shipKeep && policy != POLICY_OFF) begin
            next_regulatorOneEnable = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data mux
    logic [7:0] readValue;

    always_comb begin
        readValue = 8'h00;
        if (hitsControlOne(regAddr)) begin
            readValue[POLICY_MSB:POLICY_LSB] = policy;
            readValue[PG_ENABLE_BIT]         = pgEnable;
            readValue[PG_STATUS_BIT]         = pgLevel & pgEnable;
            readValue[SHIP_KEEP_BIT]         = shipKeep;
        end else if (hitsVoltageTwo(regAddr)) begin
            readValue[BYPASS_BIT]  = bypass;
            readValue[VCODE_MSB:0] = vcodeTwo;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read port outputs
    logic [7:0] next_regReadData;
    logic       next_regReadValid;

    always_comb begin
        next_regReadData  = regReadData;
        next_regReadValid = regRead;
        if (regRead) begin
            next_regReadData = readValue;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            regReadData  <= 8'h00;
            regReadValid <= 1'b0;
        end else begin
            regReadData  <= next_regReadData;
            regReadValid <= next_regReadValid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Regulator drive outputs
    logic       next_regulatorOnePowerGoodEnable;
    logic       next_regulatorOneSkipShipDown;
    logic [5:0] next_regulatorOneVoltageApplied;
    logic       next_regulatorTwoBypass;
    logic [5:0] next_regulatorTwoVoltageApplied;

    always_comb begin
        next_regulatorOnePowerGoodEnable = pgEnable;
        next_regulatorOneSkipShipDown    = shipKeep;
        next_regulatorOneVoltageApplied  = clampCode(regulatorOneVoltageCode);
        next_regulatorTwoBypass          = bypass;
        next_regulatorTwoVoltageApplied  = clampCode(vcodeTwo);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            regulatorOneEnable          <= 1'b0;
            regulatorOnePowerGoodEnable <= PG_ENABLE_RESET;
            regulatorOneSkipShipDown    <= SHIP_KEEP_RESET;
            regulatorOneVoltageApplied  <= VCODE_ONE_RESET;
            regulatorTwoBypass          <= BYPASS_RESET;
            regulatorTwoVoltageApplied  <= VCODE_TWO_RESET;
        end else begin
            regulatorOneEnable          <= next_regulatorOneEnable;
            regulatorOnePowerGoodEnable <= next_regulatorOnePowerGoodEnable;
            regulatorOneSkipShipDown    <= next_regulatorOneSkipShipDown;
            regulatorOneVoltageApplied  <= next_regulatorOneVoltageApplied;
            regulatorTwoBypass          <= next_regulatorTwoBypass;
            regulatorTwoVoltageApplied  <= next_regulatorTwoVoltageApplied;
        end
    end

endmodule : linear_regulator_control_regs

/* File: bench/regulator_regs_chk.sv */
`timescale 1ns/1ps
module regulator_regs_chk
    import regulator_ctrl_pkg::*;
(
    // Clock, reset and register port
    input wire logic       clk, reset_n, registerReset, regWrite, regRead, regReadValid,
    input wire logic [7:0] regAddr, regWriteData, regReadData,
    // Regulator side
    input wire logic [5:0] regulatorOneVoltageCode, regulatorOneVoltageApplied,
    input wire logic [5:0] regulatorTwoVoltageApplied,
    input wire logic       regulatorOnePowerGoodEnable, regulatorOneSkipShipDown,
    input wire logic       regulatorTwoBypass
);
    function automatic logic [5:0] clampCode(input logic [5:0] c);
        return (c > VCODE_MAX) ? VCODE_MAX : c;
    endfunction : clampCode
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    wr_one_a: assert property (regWrite && regAddr == 8'h3c && !registerReset |-> ##2
        regulatorOnePowerGoodEnable == $past(regWriteData[3], 2)
        && regulatorOneSkipShipDown == $past(regWriteData[0], 2)) else $error("ctrl one output");
    wr_two_a: assert property (regWrite && regAddr == 8'h3d && !registerReset |-> ##2
        {regulatorTwoBypass, regulatorTwoVoltageApplied}
        == {$past(regWriteData[6], 2), clampCode($past(regWriteData[5:0], 2))})
        else $error("reg two output");
    clamp_one_a: assert property (1'b1 |=>
        regulatorOneVoltageApplied == clampCode($past(regulatorOneVoltageCode)))
        else $error("reg one clamp");
    two_max_a: assert property (regulatorTwoVoltageApplied <= 6'h38) else $error("reg two max");
    rst_fields_a: assert property (registerReset |-> ##2 regulatorOnePowerGoodEnable
        && !regulatorOneSkipShipDown && regulatorTwoVoltageApplied == 6'h32) else $error("reg reset");
    resv_one_a: assert property (regRead && regAddr == 8'h3c |=> (regReadData & 8'h14) == 8'h00)
        else $error("ctrl one reserved");
    resv_two_a: assert property (regRead && regAddr == 8'h3d |=> !regReadData[7])
        else $error("reg two reserved");
    unmapped_a: assert property (regRead && regAddr != 8'h3c && regAddr != 8'h3d |=>
        regReadValid && regReadData == 8'h00) else $error("unmapped read");
endmodule : regulator_regs_chk
bind linear_regulator_control_regs regulator_regs_chk i_chk (
    .clk                        (clk),
    .reset_n                    (reset_n),
    .registerReset              (registerReset),
    .regWrite                   (regWrite),
    .regRead                    (regRead),
    .regReadValid               (regReadValid),
    .regAddr                    (regAddr),
    .regWriteData               (regWriteData),
    .regReadData                (regReadData),
    .regulatorOneVoltageCode    (regulatorOneVoltageCode),
    .regulatorOneVoltageApplied (regulatorOneVoltageApplied),
    .regulatorTwoVoltageApplied (regulatorTwoVoltageApplied),
    .regulatorOnePowerGoodEnable(regulatorOnePowerGoodEnable),
    .regulatorOneSkipShipDown   (regulatorOneSkipShipDown),
    .regulatorTwoBypass         (regulatorTwoBypass)
);

/* File: bench/sequencer_model.sv */
`timescale 1ns/1ps
module sequencer_model (
    // Requests from the bench
    input wire logic       clk, reset_n, shipRequest, goodRequest,
    input wire logic [3:0] slotRequest,
    // Levels seen by the block
    output logic [3:0] sequenceSlotActive,
    output logic       shipPowerDown, regulatorOnePowerGoodRaw
);
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) {sequenceSlotActive, shipPowerDown, regulatorOnePowerGoodRaw} <= 6'h0;
        else {sequenceSlotActive, shipPowerDown, regulatorOnePowerGoodRaw} <=
            {slotRequest, shipRequest, goodRequest};
    end
endmodule : sequencer_model

/* File: bench/tb.sv */
`timescale 1ns/1ps
module tb;
    import regulator_ctrl_pkg::*;
    typedef struct packed {logic [7:0] d; logic [3:0] s; logic p, sh, e;} row_t;
    logic clk = 0, reset_n = 0, registerReset = 0, regWrite = 0, regRead = 0, regReadValid;
    logic [7:0] regAddr = 8'h0, regWriteData = 8'h0, regReadData, q;
    logic generalPurposePinFour = 0, shipRequest = 0, goodRequest = 1, shipPowerDown;
    logic regulatorOneEnable, regulatorOnePowerGoodEnable, regulatorOneSkipShipDown;
    logic regulatorTwoBypass, regulatorOnePowerGoodRaw;
    logic [3:0] slotRequest = 4'h0, sequenceSlotActive;
    logic [5:0] regulatorOneVoltageCode = 6'h3f, regulatorOneVoltageApplied;
    logic [5:0] regulatorTwoVoltageApplied;
    int mismatches = 0, num_checks = 0;
    row_t rows [11] = '{
        '{8'h1c, 4'h1, 1'h0, 1'h0, 1'h1}, '{8'h28, 4'hd, 1'h0, 1'h0, 1'h0},
        '{8'h48, 4'h4, 1'h0, 1'h0, 1'h1}, '{8'h68, 4'h7, 1'h0, 1'h0, 1'h0},
        '{8'h88, 4'hf, 1'h0, 1'h0, 1'h0}, '{8'ha8, 4'h0, 1'h0, 1'h0, 1'h1},
        '{8'hc8, 4'hf, 1'h0, 1'h0, 1'h0}, '{8'hc8, 4'h0, 1'h1, 1'h0, 1'h1},
        '{8'he8, 4'h0, 1'h0, 1'h1, 1'h1}, '{8'ha8, 4'h0, 1'h0, 1'h1, 1'h0},
        '{8'h09, 4'h0, 1'h0, 1'h1, 1'h1}};
    always #2.5 clk = ~clk;
    sequencer_model i_seq (
        .clk                        (clk),
        .reset_n                    (reset_n),
        .shipRequest                (shipRequest),
        .goodRequest                (goodRequest),
        .slotRequest                (slotRequest),
        .sequenceSlotActive         (sequenceSlotActive),
        .shipPowerDown              (shipPowerDown),
        .regulatorOnePowerGoodRaw   (regulatorOnePowerGoodRaw)
    );
    linear_regulator_control_regs i_dut (
        .clk                        (clk),
        .reset_n                    (reset_n),
        .registerReset              (registerReset),
        .regWrite                   (regWrite),
        .regRead                    (regRead),
        .regAddr                    (regAddr),
        .regWriteData               (regWriteData),
        .regReadData                (regReadData),
        .regReadValid               (regReadValid),
        .sequenceSlotActive         (sequenceSlotActive),
        .shipPowerDown              (shipPowerDown),
        .regulatorOnePowerGoodRaw   (regulatorOnePowerGoodRaw),
        .generalPurposePinFour      (generalPurposePinFour),
        .regulatorOneVoltageCode    (regulatorOneVoltageCode),
        .regulatorOneEnable         (regulatorOneEnable),
        .regulatorOnePowerGoodEnable(regulatorOnePowerGoodEnable),
        .regulatorOneSkipShipDown   (regulatorOneSkipShipDown),
        .regulatorOneVoltageApplied (regulatorOneVoltageApplied),
        .regulatorTwoBypass         (regulatorTwoBypass),
        .regulatorTwoVoltageApplied (regulatorTwoVoltageApplied)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("Checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : conclude
    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk8
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regWrite <= 1;
        regAddr <= a;
        regWriteData <= d;
        @(posedge clk);
        regWrite <= 0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        int i;
        regRead <= 1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 0;
        for (i = 0; i < 4 && regReadValid !== 1'b1; i++) @(negedge clk);
        if (i == 4) begin
            mismatches++;
            conclude();
        end
        v = regReadData;
        @(posedge clk);
    endtask : rd
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1;
        repeat (6) @(posedge clk);
        rd(8'h3c, q);
        chk8("ctrl one reset", 8'h2a, q);
        rd(8'h3d, q);
        chk8("reg two reset", 8'h32, q);
        $display("Test reset done");
        foreach (rows[k]) begin
            slotRequest <= rows[k].s;
            generalPurposePinFour <= rows[k].p;
            shipRequest <= rows[k].sh;
            wr(8'h3c, rows[k].d);
            repeat (6) @(posedge clk);
            chk8("enable", {7'h0, rows[k].e}, {7'h0, regulatorOneEnable});
            rd(8'h3c, q);
            chk8("ctrl one", rows[k].d & 8'he9, q & 8'hfd);
        end
        $display("Test rows done");
        shipRequest <= 0;
        wr(8'h3c, 8'h20);
        rd(8'h3c, q);
        chk8("pg gated", 8'h20, q);
        wr(8'h3d, 8'hff);
        rd(8'h3d, q);
        chk8("reg two raw", 8'h7f, q);
        chk8("reg two out", 8'h78, {1'b0, regulatorTwoBypass, regulatorTwoVoltageApplied});
        chk8("reg one out", 8'h38, {2'h0, regulatorOneVoltageApplied});
        regulatorOneVoltageCode <= 6'h2a;
        repeat (2) @(posedge clk);
        chk8("reg one pass", 8'h2a, {2'h0, regulatorOneVoltageApplied});
        wr(8'h3e, 8'hff);
        rd(8'h3e, q);
        chk8("unmapped", 8'h00, q);
        wr(8'h3c, 8'h81);
        // Register reset and a write in one cycle: the reset wins
        registerReset <= 1;
        regWrite <= 1;
        regAddr <= 8'h3c;
        regWriteData <= 8'h81;
        @(posedge clk);
        registerReset <= 0;
        regWrite <= 0;
        @(posedge clk);
        rd(8'h3c, q);
        chk8("ctrl one rst", 8'h2a, q);
        rd(8'h3d, q);
        chk8("reg two rst", 8'h72, q);
        goodRequest <= 0;
        repeat (4) @(posedge clk);
        rd(8'h3c, q);
        chk8("pg low", 8'h28, q);
        wr(8'h3d, 8'h45);
        $display("Test hand cases done");
        // Reset in mid-run
        goodRequest <= 1;
        reset_n <= 0;
        repeat (3) @(posedge clk);
        q = {4'h0, regulatorOneEnable, regulatorOnePowerGoodEnable,
            regulatorOneSkipShipDown, regulatorTwoBypass};
        chk8("flags in reset", 8'h04, q);
        chk8("v1 in reset", 8'h14, {2'h0, regulatorOneVoltageApplied});
        chk8("v2 in reset", 8'h32, {2'h0, regulatorTwoVoltageApplied});
        reset_n <= 1;
        repeat (6) @(posedge clk);
        rd(8'h3c, q);
        chk8("ctrl one again", 8'h2a, q);
        rd(8'h3d, q);
        chk8("reg two again", 8'h32, q);
        $display("Test mid-run reset done");
        conclude();
    end
endmodule : tb
